//--- rtl/fpsc_pkg.sv
package fpsc_pkg;
  // Timing base
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STEP_MS = 300;
  localparam int IDLE_MS = 2000;
  localparam int DROP_MS = 20;
  localparam int FLASH_MS = 200;
  localparam int IDENT_MS = 1000;
  localparam int STEP_CYC = CYC_PER_MS * STEP_MS;
  localparam int IDLE_CYC = CYC_PER_MS * IDLE_MS;
  localparam int DROP_CYC = CYC_PER_MS * DROP_MS;
  localparam int FLASH_CYC = CYC_PER_MS * FLASH_MS;
  localparam int IDENT_CYC = CYC_PER_MS * IDENT_MS;
  // Steps held at one interval before the repeat speeds up
  localparam logic [1:0] ACC_HOLD = 2'd3;
  localparam logic [1:0] ACC_TOP = 2'd3;

  // Voltage in 0.1 V, frequency in 0.1 Hz, current limit in 1 A
  localparam logic [11:0] V_LO_MAX = 12'h5dc;
  localparam logic [11:0] V_HI_MAX = 12'hbb8;
  localparam logic [12:0] F_MIN = 13'h01c2;
  localparam logic [12:0] F_MAX = 13'h1388;
  localparam logic [12:0] F_BAND = 13'h03e8;
  localparam logic [12:0] F_FINE = 13'h0001;
  localparam logic [12:0] F_COARSE = 13'h000a;
  localparam logic [12:0] F_50 = 13'h01f4;
  localparam logic [12:0] F_60 = 13'h0258;
  localparam logic [6:0] I_OFF = 7'h00;
  localparam logic [6:0] I_MAX = 7'h7f;

  // APB byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SETPT = 8'h04;
  localparam logic [7:0] OFS_VLIM = 8'h08;
  localparam logic [7:0] OFS_SLOT1 = 8'h0c;
  localparam logic [7:0] OFS_SLOT2 = 8'h10;
  localparam logic [7:0] OFS_SLOT3 = 8'h14;

  // Arbitrary identity values
  localparam logic [11:0] MODEL_ID = 12'h0a5;
  localparam logic [6:0] FW_VER = 7'h12;
  localparam logic [3:0] ERR_OVERCURRENT = 4'h1;

  typedef struct packed {
    logic v_up, v_dn, f_up, f_dn, i_up, i_dn;
    logic p50, p60, rng, outk, lock, ppf;
    logic [2:0] slot;
  } fpsc_keys_t;

  typedef struct packed {
    logic [6:0] cur;
    logic [12:0] freq;
    logic [11:0] volt;
  } fpsc_set_t;

  typedef struct packed {
    logic [3:0] rsv1;
    logic [11:0] hi;
    logic [3:0] rsv0;
    logic [11:0] lo;
  } fpsc_vlim_t;

  localparam fpsc_set_t SET_RST = '{cur: I_OFF, freq: F_60, volt: 12'h000};
  localparam fpsc_vlim_t VLIM_RST = '{4'h0, V_HI_MAX, 4'h0, 12'h000};

  // Gray codes along normal -> volt -> freq -> cur
  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_VOLT = 2'b01,
    MD_FREQ = 2'b11,
    MD_CUR = 2'b10
  } fpsc_mode_t;
endpackage

//--- rtl/fpsc_panel.sv
`timescale 1ns/100ps
// Behaviour
// - Voltage keys step the setpoint every 0.3 s, faster while held.
// - Frequency keys step every 0.3 s and accelerate while held.
// - Voltage idle 2 s: flash once, latch setpoint, leave voltage mode.
// - Frequency idle 2 s: flash once, latch setpoint, leave frequency mode.
// - Frequency step 0.1 Hz below 100 Hz, 1 Hz from 100 to 500.
// - Preset keys load 50 Hz or 60 Hz whenever the panel is unlocked and past the power-on identity display.
// - Two voltage ranges, 0-150 V and 0-300 V, toggled by range key.
// - Range never changes by itself, only on the range key.
// - Range toggle with output on keeps setpoint, drops output 20 ms.
// - Refuse a range toggle that conflicts with the stored voltage limits.
// - Voltage adjustable in standby and with output on.
// - Output key toggles output, or clears a latched fault; its indicator lit while on and through range dropout.
// - Manual setpoint changes never write the stored slots.
// - Current limit keys adjust; 2 s idle returns to previous display.
// - Current limit OFF still limits at built-in capacity.
// - Panel lock ignores all keys but power/PF select and lock.
// - Fault shutdown shows error code on frequency display; overcurrent code.
// - At power-on show model on voltage, firmware on current display.
// - Three slots of V, F, I; slot key during test outputs them.
// - Frequency adjustable in standby and with output on.
// - Current limit adjustable in standby and with output on.
// - Frequency clamps at 45 Hz going down and 500 Hz going up.
module fpsc_panel
  import fpsc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC,   // base repeat period
  parameter int IDLE_CYCLES = IDLE_CYC,   // commit timeout
  parameter int DROP_CYCLES = DROP_CYC,   // range change dropout
  parameter int FLASH_CYCLES = FLASH_CYC, // display flash length
  parameter int IDENT_CYCLES = IDENT_CYC  // power-on identity time
) (
  input wire logic pclk,              // APB clock
  input wire logic presetn,           // async reset, low
  input wire logic psel,              // APB select
  input wire logic penable,           // APB enable
  input wire logic pwrite,            // APB direction
  input wire logic [7:0] paddr,       // APB byte address
  input wire logic [31:0] pwdata,     // APB write data
  output logic [31:0] prdata,         // APB read data
  output logic pready,                // APB ready
  output logic pslverr,               // APB error
  input wire fpsc_keys_t keys_raw,    // pushbuttons, high pressed
  input wire logic oc_fault_raw,      // overcurrent trip
  output logic [11:0] volt_disp,      // voltage display value
  output logic [12:0] freq_disp,      // frequency display value
  output logic [6:0] cur_disp,        // current display value
  output logic err_show,              // freq display holds error code
  output logic [11:0] volt_out,       // latched voltage setpoint
  output logic [12:0] freq_out,       // latched frequency setpoint
  output logic [6:0] cur_lim,         // effective current limit
  output logic out_en,                // power stage enable
  output logic out_led,               // output indicator
  output logic lo_rng_led,            // low range indicator
  output logic hi_rng_led,            // high range indicator
  output logic lock_led,              // lock indicator
  output logic [2:0] slot_led,        // selected slot indicators
  output logic ppf_sel,               // power/PF display select
  output logic flash_volt,            // voltage display blank
  output logic flash_freq,            // frequency display blank
  output logic id_show                // identity shown
);
  localparam int RW = $clog2(STEP_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int DW = $clog2(DROP_CYCLES + 1);
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam int NW = $clog2(IDENT_CYCLES + 1);

  if (STEP_CYCLES < 8 || IDLE_CYCLES < 2 || DROP_CYCLES < 2 ||
      FLASH_CYCLES < 2 || IDENT_CYCLES < 2) begin : g_bad_param
    $error("fpsc_panel: timing parameters too small");
  end

  // Pin synchroniser, a bit moves once stages two and three agree
  logic [15:0] raw, s1_ff, s2_ff, s3_ff, db_ff, prv_ff, nxt_db;
  assign raw = {keys_raw, oc_fault_raw};
  assign nxt_db = (s3_ff & ~(s2_ff ^ s3_ff)) | (db_ff & (s2_ff ^ s3_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      db_ff <= '0;
      prv_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      db_ff <= nxt_db;
      prv_ff <= db_ff;
    end
  end

  fpsc_keys_t keys, press, ok, pr, hd;
  assign keys = fpsc_keys_t'(db_ff[15:1]);
  assign press = fpsc_keys_t'(db_ff[15:1] & ~prv_ff[15:1]);

  // Panel state
  logic [11:0] volt_ff, nxt_volt, vmax;
  logic [12:0] freq_ff, nxt_freq;
  logic [6:0] cur_ff, nxt_cur;
  fpsc_set_t set_ff, nxt_set;
  fpsc_mode_t mode_ff, nxt_mode, prev_ff, nxt_prev;
  logic rng_ff, nxt_rng, on_ff, nxt_on, flt_ff, nxt_flt;
  logic lock_ff, nxt_lock, ppf_ff, nxt_ppf, flv_ff, nxt_flv;
  logic flf_ff, nxt_flf;
  logic [2:0] sel_ff, nxt_sel;
  logic [1:0] lvl_ff, nxt_lvl, lcnt_ff, nxt_lcnt;
  logic [RW-1:0] rpt_ff, nxt_rpt;
  logic [IW-1:0] idle_ff, nxt_idle;
  logic [DW-1:0] drop_ff, nxt_drop;
  logic [FW-1:0] fl_ff, nxt_fl;
  logic [NW-1:0] id_ff, nxt_id;
  logic stp, adj_pr, adj_hd;
  fpsc_vlim_t vlim_ff, nxt_vlim;
  fpsc_set_t slot_ff [3];
  fpsc_set_t nxt_slot [3];

  always_comb begin
    ok = '1;
    if (id_ff != '0) begin
      ok = '0;
    end else if (lock_ff) begin
      ok = '0;
      ok.lock = 1'b1;
      ok.ppf = 1'b1;
    end
    pr = fpsc_keys_t'(press & ok);
    hd = fpsc_keys_t'(keys & ok);
  end

  assign adj_pr = pr.v_up | pr.v_dn | pr.f_up | pr.f_dn | pr.i_up | pr.i_dn;
  assign adj_hd = hd.v_up | hd.v_dn | hd.f_up | hd.f_dn | hd.i_up | hd.i_dn;

  always_comb begin
    nxt_volt = volt_ff;
    nxt_freq = freq_ff;
    nxt_cur = cur_ff;
    nxt_set = set_ff;
    nxt_mode = mode_ff;
    nxt_prev = prev_ff;
    nxt_rng = rng_ff;
    nxt_on = on_ff;
    nxt_flt = flt_ff;
    nxt_lock = lock_ff;
    nxt_ppf = ppf_ff;
    nxt_flv = flv_ff;
    nxt_flf = flf_ff;
    nxt_sel = sel_ff;
    nxt_lvl = lvl_ff;
    nxt_lcnt = lcnt_ff;
    nxt_rpt = rpt_ff;
    nxt_idle = idle_ff;
    nxt_drop = drop_ff;
    nxt_fl = fl_ff;
    nxt_id = id_ff;
    stp = 1'b0;
    vmax = rng_ff ? V_HI_MAX : V_LO_MAX;
    if (vlim_ff.hi < vmax) begin
      vmax = vlim_ff.hi;
    end
    if (id_ff != '0) begin
      nxt_id = id_ff - NW'(1);
    end
    if (drop_ff != '0) begin
      nxt_drop = drop_ff - DW'(1);
    end
    if (fl_ff != '0) begin
      nxt_fl = fl_ff - FW'(1);
    end else begin
      nxt_flv = 1'b0;
      nxt_flf = 1'b0;
    end

    if (adj_pr) begin
      stp = 1'b1;
      nxt_rpt = RW'(STEP_CYCLES - 1);
      nxt_lvl = '0;
      nxt_lcnt = '0;
    end else if (adj_hd) begin
      if (rpt_ff == '0) begin
        stp = 1'b1;
        nxt_lcnt = lcnt_ff + 2'd1;
        if (lcnt_ff == ACC_HOLD && lvl_ff != ACC_TOP) begin
          nxt_lvl = lvl_ff + 2'd1;
        end
        nxt_rpt = RW'((STEP_CYCLES >> nxt_lvl) - 1);
      end else begin
        nxt_rpt = rpt_ff - RW'(1);
      end
    end

    if (stp) begin
      nxt_idle = IW'(IDLE_CYCLES - 1);
      if (hd.v_up | hd.v_dn) begin
        nxt_mode = MD_VOLT;
        if (hd.v_up && volt_ff < vmax) begin
          nxt_volt = volt_ff + 12'd1;
        end else if (hd.v_dn && volt_ff > vlim_ff.lo) begin
          nxt_volt = volt_ff - 12'd1;
        end
      end else if (hd.f_up | hd.f_dn) begin
        nxt_mode = MD_FREQ;
        if (hd.f_up) begin
          if (freq_ff < F_BAND) begin
            nxt_freq = freq_ff + F_FINE;
          end else if (freq_ff <= F_MAX - F_COARSE) begin
            nxt_freq = freq_ff + F_COARSE;
          end else begin
            nxt_freq = F_MAX;
          end
        end else if (freq_ff > F_BAND) begin
          nxt_freq = freq_ff - F_COARSE;
        end else if (freq_ff > F_MIN) begin
          nxt_freq = freq_ff - F_FINE;
        end
      end else begin
        if (mode_ff != MD_CUR) begin
          nxt_prev = mode_ff;
        end
        nxt_mode = MD_CUR;
        if (hd.i_up && cur_ff != I_MAX) begin
          nxt_cur = cur_ff + 7'd1;
        end else if (hd.i_dn && cur_ff != I_OFF) begin
          nxt_cur = cur_ff - 7'd1;
        end
      end
    end else if (mode_ff != MD_NORMAL) begin
      if (idle_ff != '0) begin
        nxt_idle = idle_ff - IW'(1);
      end else begin
        nxt_mode = MD_NORMAL;
        unique case (mode_ff)
          MD_VOLT: begin
            nxt_set.volt = volt_ff;
            nxt_flv = 1'b1;
            nxt_fl = FW'(FLASH_CYCLES - 1);
          end
          MD_FREQ: begin
            nxt_set.freq = freq_ff;
            nxt_flf = 1'b1;
            nxt_fl = FW'(FLASH_CYCLES - 1);
          end
          MD_CUR: begin
            nxt_set.cur = cur_ff;
            nxt_mode = prev_ff;
            nxt_idle = IW'(IDLE_CYCLES - 1);
          end
          MD_NORMAL: begin
          end
        endcase
      end
    end

    if (pr.p50) begin
      nxt_freq = F_50;
      nxt_set.freq = F_50;
    end else if (pr.p60) begin
      nxt_freq = F_60;
      nxt_set.freq = F_60;
    end

    if (pr.rng && (rng_ff ? vlim_ff.lo <= V_LO_MAX : 1'b1)) begin
      nxt_rng = ~rng_ff;
      if (on_ff) begin
        nxt_drop = DW'(DROP_CYCLES - 1);
      end
    end

    if (on_ff && pr.slot != 3'b000) begin
      for (int k = 2; k >= 0; k--) begin
        if (pr.slot[k]) begin
          nxt_sel = 3'b001 << k;
          nxt_volt = slot_ff[k].volt;
          nxt_freq = slot_ff[k].freq;
          nxt_cur = slot_ff[k].cur;
          nxt_set = slot_ff[k];
        end
      end
      nxt_mode = MD_NORMAL;
    end

    if (pr.lock) begin
      nxt_lock = ~lock_ff;
    end
    if (pr.ppf) begin
      nxt_ppf = ~ppf_ff;
    end
    if (pr.outk) begin
      if (flt_ff) begin
        nxt_flt = 1'b0;
      end else begin
        nxt_on = ~on_ff;
      end
    end
    if (db_ff[0] && on_ff) begin
      nxt_on = 1'b0;
      nxt_flt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_ff <= SET_RST.volt;
      freq_ff <= SET_RST.freq;
      cur_ff <= SET_RST.cur;
      set_ff <= SET_RST;
      mode_ff <= MD_NORMAL;
      prev_ff <= MD_NORMAL;
      rng_ff <= 1'b0;
      on_ff <= 1'b0;
      flt_ff <= 1'b0;
      lock_ff <= 1'b0;
      ppf_ff <= 1'b0;
      flv_ff <= 1'b0;
      flf_ff <= 1'b0;
      sel_ff <= 3'b000;
      lvl_ff <= '0;
      lcnt_ff <= '0;
      rpt_ff <= '0;
      idle_ff <= '0;
      drop_ff <= '0;
      fl_ff <= '0;
      id_ff <= NW'(IDENT_CYCLES - 1);
    end else begin
      volt_ff <= nxt_volt;
      freq_ff <= nxt_freq;
      cur_ff <= nxt_cur;
      set_ff <= nxt_set;
      mode_ff <= nxt_mode;
      prev_ff <= nxt_prev;
      rng_ff <= nxt_rng;
      on_ff <= nxt_on;
      flt_ff <= nxt_flt;
      lock_ff <= nxt_lock;
      ppf_ff <= nxt_ppf;
      flv_ff <= nxt_flv;
      flf_ff <= nxt_flf;
      sel_ff <= nxt_sel;
      lvl_ff <= nxt_lvl;
      lcnt_ff <= nxt_lcnt;
      rpt_ff <= nxt_rpt;
      idle_ff <= nxt_idle;
      drop_ff <= nxt_drop;
      fl_ff <= nxt_fl;
      id_ff <= nxt_id;
    end
  end

  // Registered outputs
  logic [11:0] nxt_vd;
  logic [12:0] nxt_fd;
  logic [6:0] nxt_cd, nxt_cl;
  logic nxt_oe;
  always_comb begin
    nxt_vd = (id_ff != '0) ? MODEL_ID : volt_ff;
    nxt_cd = (id_ff != '0) ? FW_VER : cur_ff;
    nxt_fd = flt_ff ? {9'h000, ERR_OVERCURRENT} : freq_ff;
    // OFF means capacity, halved on high range
    nxt_cl = set_ff.cur;
    if (set_ff.cur == I_OFF) begin
      nxt_cl = rng_ff ? (I_MAX >> 1) : I_MAX;
    end
    // Built from next values so stage and lamp switch on the same edge
    nxt_oe = nxt_on && nxt_drop == '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_disp <= '0;
      freq_disp <= '0;
      cur_disp <= '0;
      cur_lim <= '0;
      out_en <= 1'b0;
    end else begin
      volt_disp <= nxt_vd;
      freq_disp <= nxt_fd;
      cur_disp <= nxt_cd;
      cur_lim <= nxt_cl;
      out_en <= nxt_oe;
    end
  end

  assign err_show = flt_ff;
  assign volt_out = set_ff.volt;
  assign freq_out = set_ff.freq;
  assign out_led = on_ff;
  assign lo_rng_led = ~rng_ff;
  assign hi_rng_led = rng_ff;
  assign lock_led = lock_ff;
  assign slot_led = sel_ff;
  assign ppf_sel = ppf_ff;
  assign flash_volt = flv_ff;
  assign flash_freq = flf_ff;
  assign id_show = id_ff != '0;

  // APB slave, zero wait: read data is captured in the setup cycle
  logic [31:0] nxt_rd;
  logic nxt_err, wr;
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  always_comb begin
    nxt_vlim = vlim_ff;
    nxt_slot = slot_ff;
    nxt_rd = prdata;
    nxt_err = pslverr;
    if (psel && !penable) begin
      nxt_err = 1'b0;
      unique case (paddr)
        OFS_STATUS: nxt_rd = {20'h00000, flv_ff, flf_ff, mode_ff,
                              sel_ff, ppf_ff, flt_ff, lock_ff, rng_ff, on_ff};
        OFS_SETPT: nxt_rd = set_ff;
        OFS_VLIM: nxt_rd = vlim_ff;
        OFS_SLOT1: nxt_rd = slot_ff[0];
        OFS_SLOT2: nxt_rd = slot_ff[1];
        OFS_SLOT3: nxt_rd = slot_ff[2];
        default: begin
          nxt_rd = '0;
          nxt_err = 1'b1;
        end
      endcase
    end
    if (wr) begin
      if (paddr == OFS_VLIM) begin
        nxt_vlim = fpsc_vlim_t'(pwdata & 32'h0fff0fff);
      end
      for (int k = 0; k < 3; k++) begin
        if (paddr == OFS_SLOT1 + 8'(4 * k)) begin
          nxt_slot[k] = fpsc_set_t'(pwdata);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlim_ff <= VLIM_RST;
      slot_ff <= '{SET_RST, SET_RST, SET_RST};
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      vlim_ff <= nxt_vlim;
      slot_ff <= nxt_slot;
      prdata <= nxt_rd;
      pslverr <= nxt_err;
    end
  end
endmodule // fpsc_panel

//--- test/fpsc_checker.sv
`timescale 1ns/100ps
module fpsc_checker
  import fpsc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [7:0] paddr, // address
  input wire logic pslverr, // error
  input wire fpsc_keys_t keys_raw, // buttons
  input wire logic [11:0] volt_disp, // voltage shown
  input wire logic [12:0] freq_disp, // frequency shown
  input wire logic [6:0] cur_disp, // current shown
  input wire logic err_show, // fault flag
  input wire logic [12:0] freq_out, // latched frequency
  input wire logic [6:0] cur_lim, // live limit
  input wire logic out_en, // stage enable
  input wire logic out_led, // output lamp
  input wire logic lo_rng_led, // low range lamp
  input wire logic hi_rng_led, // high range lamp
  input wire logic flash_volt, // voltage blank
  input wire logic id_show // identity phase
);
  logic [3:0] since_rng_ff;
  logic [3:0] nxt_since_rng;

  // Key filter delays the range flip, so remember a recent raw press
  always_comb begin
    nxt_since_rng = since_rng_ff;
    if (keys_raw.rng)
      nxt_since_rng = 4'h0;
    else if (since_rng_ff != 4'hf)
      nxt_since_rng = since_rng_ff + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_rng_ff <= 4'hf;
    else
      since_rng_ff <= nxt_since_rng;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_led_covers_out: assert property (
    out_en |-> out_led) else $error("stage on with lamp dark");
  a_one_range: assert property (
    lo_rng_led != hi_rng_led) else $error("range lamps disagree");
  a_range_by_key: assert property (
    $changed(lo_rng_led) |-> since_rng_ff != 4'hf)
    else $error("range moved without key");
  a_freq_in_band: assert property (
    freq_out >= F_MIN && freq_out <= F_MAX) else $error("freq out of band");
  a_limit_never_off: assert property (
    !id_show |-> cur_lim != 7'h00) else $error("current limit zero");
  a_identity_shown: assert property (
    // Three samples, so the reset release edge is not judged
    id_show [*3] |-> volt_disp == MODEL_ID && cur_disp == FW_VER)
    else $error("identity not shown");
  a_fault_code: assert property (
    err_show [*2] |-> freq_disp == {9'h000, ERR_OVERCURRENT})
    else $error("fault code missing");
  a_fault_stops: assert property (
    $rose(err_show) |-> !out_led) else $error("output on after fault");
  a_range_dropout: assert property (
    out_led && $fell(out_en) |-> (!out_en) [*8] ##[1:20] out_en)
    else $error("range dropout length wrong");
  a_flash_once: assert property (
    $rose(flash_volt) |-> flash_volt [*8] ##[1:4] !flash_volt)
    else $error("voltage flash length wrong");
  a_unmapped_err: assert property (
    psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFS_SLOT3))
    else $error("slave error wrong");
endmodule // fpsc_checker

//--- test/fpsc_operator.sv
`timescale 1ns/100ps
module fpsc_operator
  import fpsc_pkg::*;
(
  input wire logic pclk, // panel clock
  output fpsc_keys_t keys_raw, // buttons, high pressed
  output logic oc_fault_raw // load overcurrent trip
);
  logic [14:0] held;

  assign keys_raw = fpsc_keys_t'(held);

  initial begin
    held = '0;
    oc_fault_raw = 1'b0;
  end

  // Pause after release so the key filter sees a clean gap
  task automatic press(input int idx, input int hold);
    held[idx] <= 1'b1;
    repeat (hold) @(posedge pclk);
    held[idx] <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  task automatic trip(input int hold);
    oc_fault_raw <= 1'b1;
    repeat (hold) @(posedge pclk);
    oc_fault_raw <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
endmodule // fpsc_operator

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import fpsc_pkg::*;
  localparam int IDLE = 200;
  localparam int LIMIT = 40000;
  localparam int VUP = 14, FUP = 12, FDN = 11, IUP = 10, IDN = 9, P50 = 8;
  localparam int P60 = 7, RNG = 6, OUTK = 5, LOCK = 4, PPF = 3, S1 = 0;
  typedef struct {string nm; logic [31:0] lo, hi, msk; logic err;} fpsc_note_t;
  fpsc_note_t notes[$];
  fpsc_note_t n;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, w;
  fpsc_keys_t keys_raw;
  logic oc_fault_raw, err_show, out_en, out_led, lo_rng_led, hi_rng_led;
  logic lock_led, ppf_sel, flash_volt, flash_freq, id_show;
  logic [11:0] volt_disp, volt_out;
  logic [12:0] freq_disp, freq_out;
  logic [6:0] cur_disp, cur_lim;
  logic [2:0] slot_led;
  fpsc_set_t ex;
  int seed, n_mismatch, comparisons, cyc, i;
  int tf[5] = '{1000, 1000, 999, 4995, 450};
  int tk[5] = '{FDN, FUP, FUP, FUP, FDN};
  int te[5] = '{999, 1010, 1000, 5000, 450};

  fpsc_panel #(.STEP_CYCLES(64), .IDLE_CYCLES(IDLE), .DROP_CYCLES(20),
    .FLASH_CYCLES(10), .IDENT_CYCLES(30)) i_fpsc_panel (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keys_raw(keys_raw),
    .oc_fault_raw(oc_fault_raw), .volt_disp(volt_disp),
    .freq_disp(freq_disp), .cur_disp(cur_disp), .err_show(err_show),
    .volt_out(volt_out), .freq_out(freq_out), .cur_lim(cur_lim),
    .out_en(out_en), .out_led(out_led), .lo_rng_led(lo_rng_led),
    .hi_rng_led(hi_rng_led), .lock_led(lock_led), .slot_led(slot_led),
    .ppf_sel(ppf_sel), .flash_volt(flash_volt), .flash_freq(flash_freq),
    .id_show(id_show));

  fpsc_operator i_fpsc_operator (.pclk(pclk), .keys_raw(keys_raw),
    .oc_fault_raw(oc_fault_raw));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end

  // Writes carry an empty mask so only the error flag is judged
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      comparisons++;
      if (!(pslverr === n.err && ((prdata & n.msk) >= n.lo) === 1'b1 &&
          ((prdata & n.msk) <= n.hi) === 1'b1)) begin
        n_mismatch++;
        $display("unexpected %s: expected %h..%h seen %h err %b",
          n.nm, n.lo, n.hi, prdata & n.msk, pslverr);
      end
    end
  end

  task automatic acc(input string nm, input logic wr, input logic [7:0] a,
      input logic [31:0] d, lo, hi, msk, input logic err);
    notes.push_back('{nm, lo, hi, msk, err});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m);
    acc(nm, 1'b0, a, 32'h0, e & m, e & m, m, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc("write", 1'b1, a, d, 32'h0, 32'h0, 32'h0, 1'b0);
  endtask

  // Direct look at a settled pin
  task automatic pin(input string nm, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  // Short press, always below one repeat period
  task automatic key(input int k);
    i_fpsc_operator.press(k, 8 + ($random(seed) & 7));
  endtask

  task automatic settle;
    repeat (IDLE + 40) @(posedge pclk);
  endtask

  initial begin
    seed = 13306;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ex = SET_RST;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("status", OFS_STATUS, 32'h0, 32'hf1f);
    rd("vlim", OFS_VLIM, VLIM_RST, '1);
    for (i = 0; i < 3; i++)
      rd("slot", OFS_SLOT1 + 8'(4 * i), SET_RST, '1);
    acc("unmapped", 1'b0, 8'h40, 32'h0, 32'h0, 32'h0, '1, 1'b1);
    acc("unmapped", 1'b1, 8'h44, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1);
    wr(OFS_SETPT, 32'hffffffff);
    rd("setpt", OFS_SETPT, ex, '1);
    for (i = 0; i < 100 && id_show !== 1'b0; i++)
      @(posedge pclk);
    key(VUP);
    rd("status", OFS_STATUS, 32'h100, 32'hf1f);
    settle();
    ex.volt = 12'h001;
    rd("setpt", OFS_SETPT, ex, '1);
    key(OUTK);
    rd("status", OFS_STATUS, 32'h1, 32'hf1f);
    pin("out_led", 32'h1, 32'(out_led));
    key(RNG);
    rd("status", OFS_STATUS, 32'h3, 32'hf1f);
    rd("setpt", OFS_SETPT, ex, '1);
    wr(OFS_VLIM, {4'h0, V_HI_MAX, 4'h0, 12'h640});
    key(RNG);
    rd("status", OFS_STATUS, 32'h3, 32'hf1f);
    wr(OFS_VLIM, VLIM_RST);
    key(RNG);
    rd("status", OFS_STATUS, 32'h1, 32'hf1f);
    for (i = 0; i < 5; i++) begin
      w = {7'h00, 13'(tf[i]), 12'(({$random(seed)} % 1400))};
      wr(OFS_SLOT1, w);
      key(S1);
      ex = fpsc_set_t'(w);
      rd("recall", OFS_SETPT, ex, '1);
      pin("slot_led", 32'h1, 32'(slot_led));
      key(tk[i]);
      settle();
      ex.freq = 13'(te[i]);
      rd("freq", OFS_SETPT, ex, '1);
      rd("slot", OFS_SLOT1, w, '1);
    end
    key(P50);
    ex.freq = F_50;
    rd("preset", OFS_SETPT, ex, '1);
    key(P60);
    ex.freq = F_60;
    rd("preset", OFS_SETPT, ex, '1);
    key(IUP);
    rd("status", OFS_STATUS, 32'h201, 32'hf1f);
    settle();
    ex.cur = 7'h01;
    rd("setpt", OFS_SETPT, ex, '1);
    rd("status", OFS_STATUS, 32'h1, 32'hf1f);
    key(IDN);
    settle();
    ex.cur = I_OFF;
    rd("setpt", OFS_SETPT, ex, '1);
    pin("cur_lim", 32'(I_MAX), 32'(cur_lim));
    pin("volt_out", 32'(ex.volt), 32'(volt_out));
    key(LOCK);
    key(VUP);
    key(P50);
    key(PPF);
    settle();
    rd("setpt", OFS_SETPT, ex, '1);
    rd("status", OFS_STATUS, 32'h15, 32'hf1f);
    pin("lock_led", 32'h1, 32'(lock_led));
    key(LOCK);
    key(PPF);
    i_fpsc_operator.trip(10);
    rd("status", OFS_STATUS, 32'h8, 32'hf1f);
    key(OUTK);
    rd("status", OFS_STATUS, 32'h0, 32'hf1f);
    key(OUTK);
    i_fpsc_operator.press(VUP, 400);
    settle();
    acc("accel", 1'b0, OFS_SETPT, 32'h0, 32'(ex.volt) + 32'd8,
      32'(ex.volt) + 32'd51, 32'hfff, 1'b0);
    final_report();
  end
endmodule // testbench

bind fpsc_panel fpsc_checker i_fpsc_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .keys_raw(keys_raw), .volt_disp(volt_disp), .freq_disp(freq_disp),
  .cur_disp(cur_disp), .err_show(err_show), .freq_out(freq_out),
  .cur_lim(cur_lim), .out_en(out_en), .out_led(out_led),
  .lo_rng_led(lo_rng_led), .hi_rng_led(hi_rng_led),
  .flash_volt(flash_volt), .id_show(id_show));
